// ---- rtl/rotary_event_pkg.sv ----
// Operation
// - queue register at address 0x00: more, empty, overflow flags, event code.
// - any write to 0x00 flushes all entries; written byte is not stored.
// - pop with entries remaining returns more flag 1, empty flag 0.
// - event into full queue is dropped; older kept; overflow flag returned.
// - reading final entry with overflow set clears the overflow indication.
// - empty or flushed queue reads 0x40 until a new event queues.
// - release event queued with code bits all zero.
// - touch event queued with bit 4 set and position in bits 3:0.
// - interrupt cleared by access re-arms only after queue emptied by reads.
// - touches queue only if touch enabled; releases only if release enabled.
package rotary_event_pkg;
	// ----------------------------------------------------------------
	// register map and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] QUEUE_ADDR = 8'h00;
	localparam int MORE_BIT = 7;
	localparam int EMPTY_BIT = 6;
	localparam int OVF_BIT = 5;
	localparam int TOUCH_BIT = 4;
	localparam logic [7:0] EMPTY_PATTERN = 8'h40;
	localparam logic [7:0] ANSWER_RESET = 8'h00;
	localparam logic [4:0] RELEASE_CODE = 5'h00;
	localparam int QUEUE_DEPTH = 8;
	localparam int CODE_W = 5;
endpackage

// ---- rtl/event_store.sv ----
`timescale 1ns/1ns
// small ring memory holding event codes; no reset needed on the data
module event_store
	import rotary_event_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	// clock
	input wire logic clk,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [CODE_W-1:0] wr_data,
	// read side
	input wire logic [AW-1:0] rd_addr,
	output logic [CODE_W-1:0] rd_data
);
	logic [CODE_W-1:0] mem [DEPTH];

	// memory write, no reset so it maps to plain storage
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule // event_store

// ---- rtl/rotary_event_fifo.sv ----
`timescale 1ns/1ns
module rotary_event_fifo
	import rotary_event_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// rotary events
	input wire logic touch_evt,
	input wire logic [3:0] touch_pos,
	input wire logic release_evt,
	// configuration
	input wire logic touch_queue_enable,
	input wire logic release_queue_enable,
	// register access strobes
	input wire logic rd_stb,
	input wire logic wr_stb,
	input wire logic [7:0] reg_addr,
	input wire logic acc_start,
	// register answer and interrupt
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic irq_n
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic ovf_reg, ovf_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	logic irq_n_reg, irq_n_next;
	logic armed_reg, armed_next;
	logic [CODE_W-1:0] head;
	logic is_rd, is_wr, evt_ok, push;
	// pop and what remains after it, shared by the push decision
	logic pop;
	logic [CW-1:0] left;
	logic [CODE_W-1:0] evt_code;

	assign is_rd = rd_stb && (reg_addr == QUEUE_ADDR);
	assign is_wr = wr_stb && (reg_addr == QUEUE_ADDR);

	// ring step used by both ends; depth need not be a power of two
	function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
		ptr_step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// touch takes priority if both arrive together
	always_comb begin
		evt_ok = 1'b0;
		evt_code = RELEASE_CODE;
		if (touch_evt && touch_queue_enable) begin
			evt_ok = 1'b1;
			evt_code = {1'b1, touch_pos};
		end else if (release_evt && release_queue_enable) begin
			evt_ok = 1'b1;
		end
	end

	event_store #(.DEPTH(DEPTH), .AW(AW)) u_store (
		.clk(clk),
		.wr_en(push),
		.wr_addr(wp_reg),
		.wr_data(evt_code),
		.rd_addr(rp_reg),
		.rd_data(head)
	);

	// ----------------------------------------------------------------
	// queue pointers, overflow and read answer
	// ----------------------------------------------------------------
	always_comb begin
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_next = cnt_reg;
		ovf_next = ovf_reg;
		rd_data_next = rd_data_reg;
		rd_valid_next = is_rd;
		push = 1'b0;
		pop = is_rd && (cnt_reg != '0);
		left = cnt_reg - CW'(pop);
		if (is_wr) begin
			// flush: byte discarded, everything dropped
			wp_next = '0;
			rp_next = '0;
			cnt_next = '0;
			ovf_next = 1'b0;
		end else begin
			if (is_rd) begin
				if (cnt_reg == '0) begin
					rd_data_next = EMPTY_PATTERN;
				end else begin
					rd_data_next = {left != '0, 1'b0, ovf_reg, head};
				end
			end
			if (pop) begin
				rp_next = ptr_step(rp_reg);
				if (left == '0) begin
					ovf_next = 1'b0;
				end
			end
			if (evt_ok) begin
				if (left == FULL_CNT) begin
					ovf_next = 1'b1;
				end else begin
					push = 1'b1;
					wp_next = ptr_step(wp_reg);
				end
			end
			cnt_next = left + CW'(push);
		end
	end

	// ----------------------------------------------------------------
	// interrupt: cleared by any access, re-armed once reads empty it
	// ----------------------------------------------------------------
	always_comb begin
		irq_n_next = irq_n_reg;
		armed_next = armed_reg;
		if (acc_start) begin
			irq_n_next = 1'b1;
			armed_next = 1'b0;
		end
		// reading the queue dry re-arms; a flush does not count
		if (is_rd && cnt_next == '0 && !is_wr) begin
			armed_next = 1'b1;
		end
		// new event raises while armed or when the same read empties the queue; it wins over the clear
		if (push && (armed_reg || (is_rd && cnt_reg <= CW'(1)))) begin
			irq_n_next = 1'b0;
		end
	end

	// queue state registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
			ovf_reg <= 1'b0;
			rd_data_reg <= ANSWER_RESET;
			rd_valid_reg <= 1'b0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
			ovf_reg <= ovf_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	// interrupt registers; kept active low so the pin is a bare flop
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_n_reg <= 1'b1;
			armed_reg <= 1'b1;
		end else begin
			irq_n_reg <= irq_n_next;
			armed_reg <= armed_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;
	assign irq_n = irq_n_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_empty_read: assert property (@(posedge clk) disable iff (sys_rst)
		(is_rd && !is_wr && cnt_reg == '0) |=> rd_data == EMPTY_PATTERN)
		else $error("empty read not 0x40");
	chk_flush_clears: assert property (@(posedge clk) disable iff (sys_rst)
		is_wr |=> cnt_reg == '0 && !ovf_reg)
		else $error("flush left entries");
	chk_more_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(is_rd && !is_wr && cnt_reg > CW'(1))
		|=> rd_data[MORE_BIT] && !rd_data[EMPTY_BIT])
		else $error("more flag wrong");
	chk_full_drop: assert property (@(posedge clk) disable iff (sys_rst)
		(evt_ok && !is_wr && !is_rd && cnt_reg == FULL_CNT)
		|=> ovf_reg && cnt_reg == FULL_CNT)
		else $error("overflow not handled");
	chk_ovf_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(is_rd && !is_wr && cnt_reg == CW'(1) && !evt_ok) |=> !ovf_reg)
		else $error("overflow not cleared");
	chk_touch_gate: assert property (@(posedge clk) disable iff (sys_rst)
		(!is_wr && !is_rd && !touch_queue_enable && !release_queue_enable)
		|=> cnt_reg == $past(cnt_reg))
		else $error("disabled event queued");
	chk_release_code: assert property (@(posedge clk) disable iff (sys_rst)
		(release_evt && !touch_evt) |-> evt_code == RELEASE_CODE)
		else $error("release code wrong");
	chk_touch_code: assert property (@(posedge clk) disable iff (sys_rst)
		(touch_evt && touch_queue_enable)
		|-> evt_code == {1'b1, touch_pos})
		else $error("touch code wrong");
	chk_irq_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_start && !push) |=> irq_n)
		else $error("irq not cleared");
	// a disarmed queue must not raise the pin for a new entry
	chk_irq_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		(push && !armed_reg && !is_rd && !acc_start && irq_n) |=> irq_n)
		else $error("irq raised while disarmed");
	chk_irq_rearm: assert property (@(posedge clk) disable iff (sys_rst)
		(is_rd && !is_wr && cnt_reg == CW'(1) && !evt_ok) |=> armed_reg)
		else $error("irq not rearmed");
	chk_ovf_report: assert property (@(posedge clk) disable iff (sys_rst)
		(is_rd && !is_wr && cnt_reg != '0)
		|=> rd_data[OVF_BIT] == $past(ovf_reg))
		else $error("overflow flag not reported");
	chk_no_answer: assert property (@(posedge clk) disable iff (sys_rst)
		(rd_stb && reg_addr != QUEUE_ADDR) |=> !rd_valid)
		else $error("unmapped read answered");
endmodule // rotary_event_fifo

// ---- sim/host_model.sv ----
`timescale 1ns/1ns
// host side of the queue register: one-cycle strobes, answer an edge later
module host_model (
	// clock
	input wire logic clk,
	// access strobes
	output logic rd_stb,
	output logic wr_stb,
	output logic acc_start,
	output logic [7:0] reg_addr,
	// answer
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	// idle bus; a released address shows a non-register value
	initial begin
		rd_stb = 1'b0;
		wr_stb = 1'b0;
		acc_start = 1'b0;
		reg_addr = 8'hFF;
	end

	// ----------------------------------------------------------------
	// one access: address acknowledge and strobe share one cycle
	// ----------------------------------------------------------------
	task automatic access(input logic rd, input logic [7:0] a,
		output logic [7:0] d, output bit ok);
		@(posedge clk);
		acc_start <= 1'b1;
		rd_stb <= rd;
		wr_stb <= !rd;
		reg_addr <= a;
		@(posedge clk);
		acc_start <= 1'b0;
		rd_stb <= 1'b0;
		wr_stb <= 1'b0;
		reg_addr <= 8'hFF;
		ok = !rd;
		d = 8'h00;
		// bounded wait so a silent device cannot hang the run
		for (int n = 0; n < 4 && rd && !ok; n++) begin
			#1;
			ok = (rd_valid === 1'b1);
			d = rd_data;
			if (!ok) @(posedge clk);
		end
	endtask
endmodule // host_model

// ---- sim/rotary_event_fifo_bench.sv ----
`timescale 1ns/1ns
module rotary_event_fifo_bench;
	import rotary_event_pkg::*;
	logic clk, sys_rst, touch_evt, release_evt, rd_valid, irq_n;
	logic touch_queue_enable, release_queue_enable;
	logic rd_stb, wr_stb, acc_start;
	logic [3:0] touch_pos;
	logic [7:0] reg_addr, rd_data;
	int error_cnt = 0;
	int checked = 0;

	rotary_event_fifo u_dut (.clk, .sys_rst, .touch_evt, .touch_pos,
		.release_evt, .touch_queue_enable, .release_queue_enable, .rd_stb,
		.wr_stb, .reg_addr, .acc_start, .rd_data, .rd_valid, .irq_n);
	host_model u_host (.clk, .rd_stb, .wr_stb, .acc_start, .reg_addr,
		.rd_data, .rd_valid);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// pop one entry; a missing answer ends the run
	task automatic rd(input logic [7:0] exp, input string nm);
		logic [7:0] d;
		bit ok;
		u_host.access(1'b1, QUEUE_ADDR, d, ok);
		if (!ok) begin
			// a missing answer is a mismatch of its own
			chk({nm, " answer"}, 8'h00, 8'h01);
			wrap_up();
		end else begin
			chk(nm, d, exp);
		end
	endtask

	// one-cycle event pulse, touch or release
	task automatic evt(input logic t, input logic [3:0] p);
		@(posedge clk);
		touch_evt <= t;
		release_evt <= !t;
		touch_pos <= p;
		@(posedge clk);
		touch_evt <= 1'b0;
		release_evt <= 1'b0;
	endtask

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		bit ok;
		sys_rst = 1'b1;
		touch_evt = 1'b0;
		release_evt = 1'b0;
		touch_pos = 4'h0;
		touch_queue_enable = 1'b1;
		release_queue_enable = 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(EMPTY_PATTERN, "reset");
		// one event more than fits, the last must be dropped
		for (int i = 0; i <= QUEUE_DEPTH; i++) evt(1'b1, i[3:0]);
		for (int i = 0; i < QUEUE_DEPTH; i++)
			rd({i < QUEUE_DEPTH - 1, 2'b01, 1'b1, i[3:0]}, "ovf");
		rd(EMPTY_PATTERN, "drained");
		for (int i = 8; i < 16; i++) evt(1'b1, i[3:0]);
		for (int i = 8; i < 16; i++)
			rd({i < 15, 2'b00, 1'b1, i[3:0]}, "pos");
		// irq stays cleared until reads empty the queue
		evt(1'b1, 4'h3);
		evt(1'b1, 4'h4);
		@(negedge clk) chk("irq set", {7'h00, irq_n}, 8'h00);
		rd(8'h93, "more");
		evt(1'b1, 4'h5);
		@(negedge clk) chk("irq held", {7'h00, irq_n}, 8'h01);
		rd(8'h94, "second");
		rd(8'h15, "last");
		evt(1'b0, 4'h0);
		@(negedge clk) chk("irq rearm", {7'h00, irq_n}, 8'h00);
		rd({3'b000, RELEASE_CODE}, "release");
		// disabled events never enter
		@(posedge clk);
		touch_queue_enable <= 1'b0;
		release_queue_enable <= 1'b0;
		evt(1'b1, 4'h2);
		evt(1'b0, 4'h0);
		rd(EMPTY_PATTERN, "gated");
		// release alone enabled: only the release enters
		@(posedge clk);
		release_queue_enable <= 1'b1;
		evt(1'b1, 4'h2);
		evt(1'b0, 4'h0);
		rd({3'b000, RELEASE_CODE}, "release only");
		rd(EMPTY_PATTERN, "touch gated");
		@(posedge clk);
		touch_queue_enable <= 1'b1;
		release_queue_enable <= 1'b1;
		evt(1'b1, 4'h1);
		evt(1'b0, 4'h0);
		u_host.access(1'b0, QUEUE_ADDR, d, ok);
		rd(EMPTY_PATTERN, "flush");
		// reset in mid-run drops the queue and idles the interrupt
		evt(1'b1, 4'h6);
		@(negedge clk) chk("pre rst irq", {7'h00, irq_n}, 8'h00);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk) chk("rst irq", {7'h00, irq_n}, 8'h01);
		rd(EMPTY_PATTERN, "rst empty");
		u_host.access(1'b1, 8'h01, d, ok);
		chk("unmapped", {7'h00, ok}, 8'h00);
		wrap_up();
	end
endmodule // rotary_event_fifo_bench
